// ===== rtl/mmpwm_top.sv
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - 32-bit counter behind 32-bit prescaler counts clock cycles, timebase for outputs.
// - Seven match registers compared with counter; matches drive events and edges.
// - Cycle match register resets the count, setting the shared period.
// - Single-edge output uses cycle register plus one edge register.
// - Single-edge output rises at cycle start, falls at its own match.
// - Double-edge output uses cycle register plus two edge registers.
// - Double-edge edges anywhere in cycle; positive or negative pulses allowed.
// - Seven registers give six single, three double, or a mix.
// - Per match: continue, stop or reset timer, each with optional interrupt.
// - Software releases new match values; applied only at cycle boundary. With modulation off, match writes apply at once.
// - Period and width any whole count; all outputs share repetition rate.
// - With modulation off, plain timer with matches and interrupts, no outputs.
module mmpwm_top
    import mmpwm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [MMPWM_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [MMPWM_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Modulated outputs, index 0 is output 1
    output logic [MMPWM_NUM_OUT-1:0] pwm_out,
    // Interrupt
    output logic irq
);
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Index of a match register word, or 7 when not a match address
    function automatic logic [2:0] match_index(input logic [MMPWM_ADDR_W-1:0] addr);
        logic [2:0] idx;
        idx = 3'h7;
        for (int i = 0; i < MMPWM_NUM_MATCH; i++) begin
            if (addr == MMPWM_OFF_MATCH0 + 8'(4 * i)) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // Register state
    logic [MMPWM_CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [31:0] prescale_q, prescale_d;
    logic [MMPWM_MC_W-1:0] mctrl_q, mctrl_d;
    logic [31:0] shadow_q [MMPWM_NUM_MATCH], shadow_d [MMPWM_NUM_MATCH];
    logic [31:0] active_q [MMPWM_NUM_MATCH], active_d [MMPWM_NUM_MATCH];
    logic [MMPWM_OC_W-1:0] octrl_q, octrl_d;
    logic [MMPWM_NUM_MATCH-1:0] release_q, release_d, status_q, status_d, mask_q, mask_d;
    logic irq_q, irq_d;

    // Bus state
    logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    // Timebase
    logic tick, pwm_mode, cycle_end;
    logic [31:0] count_q, precount_q;
    logic [MMPWM_NUM_MATCH-1:0] match, match_rst, match_stop, match_int;

    assign pwm_mode = ctrl_q[MMPWM_CTRL_PWM];

    always_comb begin
        for (int i = 0; i < MMPWM_NUM_MATCH; i++) begin
            match[i] = tick && (count_q == active_q[i]);
            match_int[i] = mctrl_q[3*i + MMPWM_MC_INT];
            match_rst[i] = mctrl_q[3*i + MMPWM_MC_RST];
            match_stop[i] = mctrl_q[3*i + MMPWM_MC_STOP];
        end
        // In modulation mode the cycle register always closes the period
        cycle_end = match[0] && (pwm_mode || match_rst[0]);
    end

    mmpwm_timebase u_timebase (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(ctrl_q[MMPWM_CTRL_RUN]),
        .hold_zero(ctrl_q[MMPWM_CTRL_HOLD]),
        .zero_on_tick(cycle_end || |(match & match_rst)),
        .prescale(prescale_q),
        .tick(tick),
        .count_q(count_q),
        .precount_q(precount_q)
    );

    // Output channels; channel n uses match n as fall, and as rise
    // either the cycle match (single edge) or match n-1 (double edge)
    genvar gn;
    generate
        for (gn = 1; gn <= MMPWM_NUM_OUT; gn++) begin : g_out
            logic dbl;
            logic rise;
            // Output 1 has no lower neighbour besides the cycle register
            assign dbl = (gn > 1) && octrl_q[MMPWM_OC_SEL_LSB + gn];
            assign rise = dbl ? match[gn-1] : match[0];
            mmpwm_edge_out u_edge (
                .aclk(aclk),
                .aresetn(aresetn),
                .enable(pwm_mode && octrl_q[MMPWM_OC_ENA_LSB + gn]),
                .rise(rise),
                .fall(match[gn]),
                .level_q(pwm_out[gn-1])
            );
        end
    endgenerate

    // Bus handshakes: write taken only with address and data together
    logic wr_take, rd_take;
    logic [2:0] wr_idx, rd_idx;
    logic [31:0] wval;

    assign wr_take = awready_q && wready_q;
    assign rd_take = arready_q;
    assign wr_idx = match_index(s_axi_awaddr);
    assign rd_idx = match_index(s_axi_araddr);

    always_comb begin
        awready_d = 1'b0;
        wready_d = 1'b0;
        if (s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q) begin
            awready_d = 1'b1;
            wready_d = 1'b1;
        end
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_take) begin
            bvalid_d = 1'b1;
            bresp_d = MMPWM_RESP_OKAY;
            if (wr_idx == 3'h7 && s_axi_awaddr != MMPWM_OFF_STATUS
                && s_axi_awaddr != MMPWM_OFF_CTRL && s_axi_awaddr != MMPWM_OFF_PRESCALE
                && s_axi_awaddr != MMPWM_OFF_MATCH_CTRL && s_axi_awaddr != MMPWM_OFF_OUT_CTRL
                && s_axi_awaddr != MMPWM_OFF_RELEASE && s_axi_awaddr != MMPWM_OFF_MASK) begin
                bresp_d = MMPWM_RESP_SLVERR;
            end
        end
    end

    // Register file next state
    always_comb begin
        ctrl_d = ctrl_q;
        prescale_d = prescale_q;
        mctrl_d = mctrl_q;
        octrl_d = octrl_q;
        mask_d = mask_q;
        release_d = release_q;
        status_d = status_q;
        wval = MMPWM_RST_WORD;
        for (int i = 0; i < MMPWM_NUM_MATCH; i++) begin
            shadow_d[i] = shadow_q[i];
            active_d[i] = active_q[i];
        end
        if (|(match & match_stop)) begin
            ctrl_d[MMPWM_CTRL_RUN] = 1'b0;
        end
        // Released values move over only at the period boundary
        if (pwm_mode && cycle_end) begin
            for (int i = 0; i < MMPWM_NUM_MATCH; i++) begin
                if (release_q[i]) begin
                    active_d[i] = shadow_q[i];
                end
            end
            release_d = '0;
        end
        if (wr_take) begin
            case (s_axi_awaddr)
                MMPWM_OFF_STATUS: begin
                    wval = merge_bytes(MMPWM_RST_WORD, s_axi_wdata, s_axi_wstrb);
                    status_d = status_q & ~wval[MMPWM_NUM_MATCH-1:0];
                end
                MMPWM_OFF_CTRL: begin
                    wval = merge_bytes(32'(ctrl_q), s_axi_wdata, s_axi_wstrb);
                    ctrl_d = wval[MMPWM_CTRL_W-1:0];
                end
                MMPWM_OFF_PRESCALE: prescale_d = merge_bytes(prescale_q, s_axi_wdata, s_axi_wstrb);
                MMPWM_OFF_MATCH_CTRL: begin
                    wval = merge_bytes(32'(mctrl_q), s_axi_wdata, s_axi_wstrb);
                    mctrl_d = wval[MMPWM_MC_W-1:0];
                end
                MMPWM_OFF_OUT_CTRL: begin
                    wval = merge_bytes(32'(octrl_q), s_axi_wdata, s_axi_wstrb);
                    octrl_d = wval[MMPWM_OC_W-1:0];
                end
                MMPWM_OFF_RELEASE: begin
                    wval = merge_bytes(32'(release_q), s_axi_wdata, s_axi_wstrb);
                    release_d = release_d | wval[MMPWM_NUM_MATCH-1:0];
                end
                MMPWM_OFF_MASK: begin
                    wval = merge_bytes(32'(mask_q), s_axi_wdata, s_axi_wstrb);
                    mask_d = wval[MMPWM_NUM_MATCH-1:0];
                end
                default: begin
                    if (wr_idx != 3'h7) begin
                        shadow_d[wr_idx] = merge_bytes(shadow_q[wr_idx], s_axi_wdata,
                                                       s_axi_wstrb);
                        // Plain timer takes the value at once
                        if (!pwm_mode) begin
                            active_d[wr_idx] = shadow_d[wr_idx];
                        end
                    end
                end
            endcase
        end
        // Hardware set wins over a clear in the same cycle
        status_d = status_d | (match & match_int);
        irq_d = |(status_d & mask_d);
    end

    // Read path
    always_comb begin
        arready_d = s_axi_arvalid && !arready_q && !rvalid_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (rd_take) begin
            rvalid_d = 1'b1;
            rresp_d = MMPWM_RESP_OKAY;
            case (s_axi_araddr)
                MMPWM_OFF_STATUS: rdata_d = 32'(status_q);
                MMPWM_OFF_CTRL: rdata_d = 32'(ctrl_q);
                MMPWM_OFF_COUNT: rdata_d = count_q;
                MMPWM_OFF_PRESCALE: rdata_d = prescale_q;
                MMPWM_OFF_PRECOUNT: rdata_d = precount_q;
                MMPWM_OFF_MATCH_CTRL: rdata_d = 32'(mctrl_q);
                MMPWM_OFF_OUT_CTRL: rdata_d = 32'(octrl_q);
                MMPWM_OFF_RELEASE: rdata_d = 32'(release_q);
                MMPWM_OFF_MASK: rdata_d = 32'(mask_q);
                default: begin
                    if (rd_idx != 3'h7) begin
                        rdata_d = shadow_q[rd_idx];
                    end else begin
                        rdata_d = MMPWM_RST_WORD;
                        rresp_d = MMPWM_RESP_SLVERR;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= '0;
            prescale_q <= MMPWM_RST_WORD;
            mctrl_q <= '0;
            octrl_q <= '0;
            release_q <= '0;
            status_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
            for (int i = 0; i < MMPWM_NUM_MATCH; i++) begin
                shadow_q[i] <= MMPWM_RST_WORD;
                active_q[i] <= MMPWM_RST_WORD;
            end
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= MMPWM_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= MMPWM_RESP_OKAY;
            rdata_q <= MMPWM_RST_WORD;
        end else begin
            ctrl_q <= ctrl_d;
            prescale_q <= prescale_d;
            mctrl_q <= mctrl_d;
            octrl_q <= octrl_d;
            release_q <= release_d;
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
            for (int i = 0; i < MMPWM_NUM_MATCH; i++) begin
                shadow_q[i] <= shadow_d[i];
                active_q[i] <= active_d[i];
            end
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign irq = irq_q;
endmodule
`default_nettype wire

// ===== rtl/mmpwm_pkg.sv
package mmpwm_pkg;
    localparam int MMPWM_ADDR_W = 8;
    localparam int MMPWM_NUM_MATCH = 7;
    localparam int MMPWM_NUM_OUT = 6;

    // Register byte offsets
    localparam logic [7:0] MMPWM_OFF_STATUS = 8'h00;
    localparam logic [7:0] MMPWM_OFF_CTRL = 8'h04;
    localparam logic [7:0] MMPWM_OFF_COUNT = 8'h08;
    localparam logic [7:0] MMPWM_OFF_PRESCALE = 8'h0c;
    localparam logic [7:0] MMPWM_OFF_PRECOUNT = 8'h10;
    localparam logic [7:0] MMPWM_OFF_MATCH_CTRL = 8'h14;
    localparam logic [7:0] MMPWM_OFF_MATCH0 = 8'h18;
    localparam logic [7:0] MMPWM_OFF_OUT_CTRL = 8'h34;
    localparam logic [7:0] MMPWM_OFF_RELEASE = 8'h38;
    localparam logic [7:0] MMPWM_OFF_MASK = 8'h3c;

    // Control register fields
    localparam int MMPWM_CTRL_RUN = 0;
    localparam int MMPWM_CTRL_HOLD = 1;
    localparam int MMPWM_CTRL_PWM = 3;
    localparam int MMPWM_CTRL_W = 4;

    // Match control: three bits per match register
    localparam int MMPWM_MC_INT = 0;
    localparam int MMPWM_MC_RST = 1;
    localparam int MMPWM_MC_STOP = 2;
    localparam int MMPWM_MC_W = 21;

    // Output control: double-edge select at bit n, enable at bit 8+n
    localparam int MMPWM_OC_SEL_LSB = 0;
    localparam int MMPWM_OC_ENA_LSB = 8;
    localparam int MMPWM_OC_W = 15;

    // Reset values
    localparam logic [31:0] MMPWM_RST_WORD = 32'h0000_0000;
    localparam logic [1:0] MMPWM_RESP_OKAY = 2'h0;
    localparam logic [1:0] MMPWM_RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/mmpwm_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module mmpwm_timebase
    import mmpwm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic run,
    input wire logic hold_zero,
    input wire logic zero_on_tick,
    input wire logic [31:0] prescale,
    // State
    output logic tick,
    output logic [31:0] count_q,
    output logic [31:0] precount_q
);
    logic [31:0] count_d;
    logic [31:0] precount_d;

    always_comb begin
        tick = run && !hold_zero && (precount_q == prescale);
        count_d = count_q;
        precount_d = precount_q;
        if (hold_zero) begin
            count_d = MMPWM_RST_WORD;
            precount_d = MMPWM_RST_WORD;
        end else if (tick) begin
            precount_d = MMPWM_RST_WORD;
            count_d = zero_on_tick ? MMPWM_RST_WORD : count_q + 32'h0000_0001;
        end else if (run) begin
            precount_d = precount_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= MMPWM_RST_WORD;
            precount_q <= MMPWM_RST_WORD;
        end else begin
            count_q <= count_d;
            precount_q <= precount_d;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/mmpwm_edge_out.sv
`timescale 1ns/1ps
`default_nettype none
module mmpwm_edge_out (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Edge events
    input wire logic enable,
    input wire logic rise,
    input wire logic fall,
    // Output level
    output logic level_q
);
    logic level_d;

    // Fall wins a tie so a zero-width pulse stays low
    always_comb begin
        level_d = level_q;
        if (!enable) begin
            level_d = 1'b0;
        end else if (fall) begin
            level_d = 1'b0;
        end else if (rise) begin
            level_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_d;
        end
    end
endmodule
`default_nettype wire

// ===== verification/mmpwm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mmpwm_asserts
    import mmpwm_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Outputs
    input wire logic [MMPWM_NUM_OUT-1:0] pwm_out,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready)
        else $error("write readies split");
    a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
        && !s_axi_bvalid |=> s_axi_awready ##1 (s_axi_bvalid && !s_axi_awready))
        else $error("write not answered in time");
    a_aw_alone: assert property (s_axi_awvalid && !s_axi_wvalid && !s_axi_awready
        |=> !s_axi_awready)
        else $error("address taken without data");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
        |=> s_axi_arready ##1 s_axi_rvalid)
        else $error("read not answered in time");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_overlap: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    a_reset_quiet: assert property ($rose(aresetn) |-> pwm_out == '0 && !irq)
        else $error("outputs active out of reset");

    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == MMPWM_RESP_SLVERR);
    c_irq: cover property ($rose(irq));
    c_neg_pulse: cover property ($fell(pwm_out[4]));
endmodule
`default_nettype wire

// ===== verification/mmpwm_load.sv
`timescale 1ns/1ps
`default_nettype none
module mmpwm_load
    import mmpwm_pkg::*;
(
    // Drive stage inputs
    input wire logic aclk,
    input wire logic [MMPWM_NUM_OUT-1:0] pwm_out,
    // Last high time and period, in clocks
    output logic [MMPWM_NUM_OUT-1:0][15:0] hi_len,
    output logic [MMPWM_NUM_OUT-1:0][15:0] per_len
);
    logic [MMPWM_NUM_OUT-1:0][15:0] hi_cnt;
    logic [MMPWM_NUM_OUT-1:0][15:0] per_cnt;
    logic [MMPWM_NUM_OUT-1:0] last;

    // A drive stage sees only the pin, so lengths latch on each edge
    // Lengths stay unknown until a whole high time or period has passed
    always @(posedge aclk) begin
        for (int k = 0; k < MMPWM_NUM_OUT; k++) begin
            hi_cnt[k] <= pwm_out[k] ? hi_cnt[k] + 16'h1 : 16'h0;
            per_cnt[k] <= (pwm_out[k] && !last[k]) ? 16'h1 : per_cnt[k] + 16'h1;
            if (!pwm_out[k] && last[k]) hi_len[k] <= hi_cnt[k];
            if (pwm_out[k] && !last[k]) per_len[k] <= per_cnt[k];
        end
        last <= pwm_out;
    end
endmodule
`default_nettype wire

// ===== verification/multi_match_pwm_generator_test.sv
`timescale 1ns/1ps
`default_nettype none
module multi_match_pwm_generator_test;
    import mmpwm_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [MMPWM_NUM_OUT-1:0] pwm_out;
    logic [MMPWM_NUM_OUT-1:0][15:0] hi_len, per_len;
    int n_mismatch;
    int n_tests;

    mmpwm_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pwm_out(pwm_out), .irq(irq));
    mmpwm_load load_u (.aclk(aclk), .pwm_out(pwm_out), .hi_len(hi_len), .per_len(per_len));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic tmo;
        $display("mismatch at %0t got %h exp %h, wait ran out", $time, 1'b0, 1'b1);
        n_mismatch++;
        test_done();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; awready !== 1'b1; n++) begin
            if (n == 50) tmo();
            @(posedge aclk);
        end
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        for (n = 0; bvalid !== 1'b1; n++) begin
            if (n == 50) tmo();
            @(posedge aclk);
        end
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; arready !== 1'b1; n++) begin
            if (n == 50) tmo();
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        for (n = 0; rvalid !== 1'b1; n++) begin
            if (n == 50) tmo();
            @(posedge aclk);
        end
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
    endtask

    task automatic t_regs;
        rd(MMPWM_OFF_CTRL, 32'h0, MMPWM_RESP_OKAY);
        // Upper bytes must be dropped by their strobes
        wstrb <= 4'h1;
        wr(MMPWM_OFF_PRESCALE, 32'hffff_ff01, MMPWM_RESP_OKAY);
        wstrb <= 4'hf;
        rd(MMPWM_OFF_PRESCALE, 32'h1, MMPWM_RESP_OKAY);
        wr(MMPWM_OFF_COUNT, 32'h5, MMPWM_RESP_SLVERR);
        rd(MMPWM_OFF_COUNT, 32'h0, MMPWM_RESP_OKAY);
        rd(8'h40, 32'h0, MMPWM_RESP_SLVERR);
        wr(8'hfc, 32'h1, MMPWM_RESP_SLVERR);
        $display("registers test done");
    endtask

    // Stop on the cycle match with interrupt; count still takes that tick
    task automatic t_timer;
        wr(MMPWM_OFF_MATCH0, 32'h9, MMPWM_RESP_OKAY);
        wr(MMPWM_OFF_MATCH_CTRL, 32'h5, MMPWM_RESP_OKAY);
        wr(MMPWM_OFF_MASK, 32'h0, MMPWM_RESP_OKAY);
        wr(MMPWM_OFF_CTRL, 32'h1, MMPWM_RESP_OKAY);
        repeat (40) @(posedge aclk);
        rd(MMPWM_OFF_COUNT, 32'h9 + 32'h1, MMPWM_RESP_OKAY);
        rd(MMPWM_OFF_CTRL, 32'h0, MMPWM_RESP_OKAY);
        rd(MMPWM_OFF_STATUS, 32'h1, MMPWM_RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        chk({26'h0, pwm_out}, 32'h0);
        wr(MMPWM_OFF_MASK, 32'h1, MMPWM_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(MMPWM_OFF_STATUS, 32'h1, MMPWM_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        $display("timer test done");
    endtask

    // Mix of four single and two double outputs, one negative-going
    task automatic t_pwm;
        int i;
        logic [31:0] p;
        logic [31:0] ew;
        logic [31:0] oc;
        logic [31:0] mv [7];
        mv = '{32'h9, 32'h3, 32'h2, 32'h7, 32'h8, 32'h1, 32'h5};
        oc = 32'h0000_7e28;
        p = mv[0] + 32'h1;
        wr(MMPWM_OFF_CTRL, 32'h2, MMPWM_RESP_OKAY);
        wr(MMPWM_OFF_PRESCALE, 32'h0, MMPWM_RESP_OKAY);
        wr(MMPWM_OFF_MATCH_CTRL, 32'h2, MMPWM_RESP_OKAY);
        for (i = 0; i < 7; i++) wr(MMPWM_OFF_MATCH0 + 8'(4 * i), mv[i], MMPWM_RESP_OKAY);
        wr(MMPWM_OFF_OUT_CTRL, oc, MMPWM_RESP_OKAY);
        wr(MMPWM_OFF_CTRL, 32'h9, MMPWM_RESP_OKAY);
        repeat (60) @(posedge aclk);
        for (i = 1; i <= 6; i++) begin
            ew = oc[i] ? (mv[i] + p - mv[i-1]) % p : mv[i] + 32'h1;
            chk({16'h0, hi_len[i-1]}, ew);
            chk({16'h0, per_len[i-1]}, p);
        end
        $display("modulation test done");
    endtask

    task automatic t_release;
        wr(MMPWM_OFF_MATCH0 + 8'h4, 32'h6, MMPWM_RESP_OKAY);
        repeat (40) @(posedge aclk);
        chk({16'h0, hi_len[0]}, 32'h4);
        rd(MMPWM_OFF_MATCH0 + 8'h4, 32'h6, MMPWM_RESP_OKAY);
        wr(MMPWM_OFF_RELEASE, 32'h2, MMPWM_RESP_OKAY);
        repeat (40) @(posedge aclk);
        chk({16'h0, hi_len[0]}, 32'h7);
        chk({16'h0, per_len[0]}, 32'ha);
        rd(MMPWM_OFF_RELEASE, 32'h0, MMPWM_RESP_OKAY);
        $display("release test done");
    endtask

    task automatic t_off;
        wr(MMPWM_OFF_CTRL, 32'h1, MMPWM_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({26'h0, pwm_out}, 32'h0);
        $display("plain timer test done");
    endtask

    initial begin
        n_mismatch = 0;
        n_tests = 0;
        aresetn = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_timer();
        t_pwm();
        t_release();
        t_off();
        test_done();
    end
endmodule

bind mmpwm_top mmpwm_asserts chk_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pwm_out(pwm_out), .irq(irq));
`default_nettype wire
